//--- sadc_pkg.sv
// Purpose: Shared constants and types for the converter sequencer.
// Assumes: AXI4-Lite register bus with 32-bit data.
// Notes: Offsets are byte addresses.
package sadc_pkg;
   localparam logic [7:0] CTRL_OFF     = 8'h00;
   localparam logic [7:0] RES0_OFF     = 8'h04;
   localparam logic [7:0] RES1_OFF     = 8'h08;
   localparam logic [7:0] RES2_OFF     = 8'h0C;
   localparam logic [7:0] RES3_OFF     = 8'h10;
   localparam logic [7:0] OPT_OFF      = 8'h14;
   localparam logic [7:0] ISTAT_OFF    = 8'h18;
   localparam logic [7:0] IMASK_OFF    = 8'h1C;
   localparam int         CCF_BIT      = 7;
   localparam int         SCAN_BIT     = 5;
   localparam int         MULTI_CHANNEL_BIT     = 4;
   localparam int         CSEL_BIT     = 0;
   localparam int         SAMPLE_CYC   = 4;
   localparam int         RC_DIV       = 100;
   localparam int         START_DLY    = 1;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   localparam logic [3:0] SEL_REF_HIGH = 4'hC;
   localparam logic [3:0] SEL_REF_LOW  = 4'hD;
   localparam logic [3:0] SEL_REF_MID  = 4'hE;
   typedef enum logic [1:0] {SADC_IDLE, SADC_WAIT, SADC_SAMPLE, SADC_CONV} sadc_state_e;
endpackage

//--- sadc_tick.sv
// Purpose: Step-enable source for the conversion sequencer.
// Assumes: Internal oscillator stands in as a divided clock.
// Notes: Pulse every cycle with the system clock selected.
`timescale 1ns/1ps
module sadc_tick
   import sadc_pkg::*;
#(
   parameter int DIV = sadc_pkg::RC_DIV
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic use_rc,
   output      logic tick
);
   logic [7:0] cnt;
   wire        wrap = (cnt == 8'(DIV - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !use_rc || wrap)
         cnt <= 8'h00;
      else
         cnt <= cnt + 8'h01;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tick <= 1'b0;
      else
         tick <= !use_rc || wrap;
   end
endmodule

//--- sadc_top.sv
// Purpose: Successive-approximation converter sequencer with AXI4-Lite registers.
// Assumes: Comparator output settles within the cycle in which the trial code is shown.
// Notes: Results are written in cycles where no read data is being latched.
// Behaviour
// R1: Eight inputs, eight-bit unsigned result.
// R2: Step timing from clock or RC oscillator.
// R3: Selector: eight inputs plus three references.
// R4: Low reference gives 00, high FF.
// R5: Eight comparison steps, MSB first.
// R6: Comparator result stored into next bit.
// R7: SAR copied to assigned result register.
// R8: Sample switch connects, then holds input.
// R9: Sequence starts one cycle after write.
// R10: Four conversions, four distinct result registers.
// R11: Complete flag after fourth result stored; a fourth result held back by a read lands one cycle after the flag sets.
// R12: Result updates never clash with reads.
// R13: Continuous or single sequence operation.
// R14: Control write restarts, aborts conversion.
// R15: Single stops after four; scan wraps.
// R16: Multi-channel uses group of four.
// R17: Flag clears on write, sets first sequence.
// R18: Idle after reset until first write.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module sadc_top
   import sadc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      logic [3:0]  mux_select,
   output      logic        sample_switch,
   output      logic [7:0]  dac_trial,
   input  wire logic        comp_out,
   output      logic        irq
);
   import sadc_pkg::*;

   logic [7:0]  ctrl;
   logic        csel;
   logic [7:0]  result [4];
   logic [7:0]  sar;
   logic [2:0]  bit_idx;
   logic [1:0]  conv_idx;
   logic [2:0]  samp_cnt;
   logic        conv_complete_flag;
   logic        first_done;
   logic        istat;
   logic        imask;
   sadc_state_e state;
   logic        aw_hold, w_hold;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        tick;

   // Write channel: address and data captured independently, in any order.
   wire wr_go    = aw_hold && w_hold && !s_axi_bvalid;
   wire rd_go    = s_axi_arvalid && s_axi_arready;
   wire ctrl_wr  = wr_go && aw_addr == CTRL_OFF && w_strb[0];
   wire opt_wr   = wr_go && aw_addr == OPT_OFF && w_strb[0];
   wire ist_wr   = wr_go && aw_addr == ISTAT_OFF && w_strb[0];
   wire msk_wr   = wr_go && aw_addr == IMASK_OFF && w_strb[0];
   wire wr_ok    = aw_addr == CTRL_OFF || aw_addr == OPT_OFF || aw_addr == ISTAT_OFF
                   || aw_addr == IMASK_OFF;
   wire rd_ok    = s_axi_araddr <= IMASK_OFF && s_axi_araddr[1:0] == 2'h0;
   wire scan     = ctrl[SCAN_BIT];
   wire multi_channel = ctrl[MULTI_CHANNEL_BIT];
   wire [3:0] chan_select = ctrl[3:0];
   wire last_bit = bit_idx == 3'h0;
   wire conv_end = state == SADC_CONV && tick && last_bit;
   wire [7:0] sar_final = {sar[7:1], comp_out};
   wire seq_end  = conv_end && conv_idx == 2'h3;
   // Results land only when no read is latching data this cycle.
   wire res_wr   = conv_end && !rd_go; // R12
   wire [3:0] next_mux = multi_channel ? {chan_select[3:2], conv_idx} : chan_select; // R16 R3

   assign s_axi_awready = !aw_hold;
   assign s_axi_wready  = !w_hold;
   assign s_axi_arready = !s_axi_rvalid;
   // The trial code is the register itself, so the comparator sees the trial being decided.
   assign dac_trial     = sar;

   sadc_tick u_tick
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .use_rc  (csel),
      .tick    (tick)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_hold)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_hold <= 1'b0;
         if (s_axi_wvalid && !w_hold)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (wr_go)
            w_hold <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            CTRL_OFF:  s_axi_rdata <= {24'h0, conv_complete_flag, 1'b0, ctrl[5:0]};
            RES0_OFF:  s_axi_rdata <= {24'h0, result[0]};
            RES1_OFF:  s_axi_rdata <= {24'h0, result[1]};
            RES2_OFF:  s_axi_rdata <= {24'h0, result[2]};
            RES3_OFF:  s_axi_rdata <= {24'h0, result[3]};
            OPT_OFF:   s_axi_rdata <= {31'h0, csel};
            ISTAT_OFF: s_axi_rdata <= {31'h0, istat};
            IMASK_OFF: s_axi_rdata <= {31'h0, imask};
            default:   s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl  <= 8'h00; // R18
         csel  <= 1'b0;
         imask <= 1'b0;
      end
      else
      begin
         if (ctrl_wr)
            ctrl <= {2'b00, w_data[5:0]};
         if (opt_wr)
            csel <= w_data[CSEL_BIT]; // R2
         if (msk_wr)
            imask <= w_data[0];
      end
   end

   // Sequencer: write restarts, one idle cycle, sample, eight trials per conversion.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state      <= SADC_IDLE; // R18
         sar        <= 8'h00;
         bit_idx    <= 3'h7;
         conv_idx   <= 2'h0;
         samp_cnt   <= 3'h0;
         first_done <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         state      <= SADC_WAIT; // R14 R9
         conv_idx   <= 2'h0;
         first_done <= 1'b0;
      end
      else
      begin
         unique case (state)
            SADC_IDLE: state <= SADC_IDLE;
            SADC_WAIT:
            begin
               state    <= SADC_SAMPLE;
               samp_cnt <= 3'h0;
            end
            SADC_SAMPLE:
               if (tick)
               begin
                  if (samp_cnt == 3'(SAMPLE_CYC - 1))
                  begin
                     state   <= SADC_CONV; // R8
                     sar     <= 8'h80; // R5
                     bit_idx <= 3'h7;
                  end
                  else
                     samp_cnt <= samp_cnt + 3'h1;
               end
            SADC_CONV:
               if (tick)
               begin
                  if (last_bit)
                  begin
                     conv_idx <= conv_idx + 2'h1; // R10 R15
                     if (seq_end)
                        first_done <= 1'b1;
                     state    <= (seq_end && !scan) ? SADC_IDLE : SADC_SAMPLE; // R13 R15
                     samp_cnt <= 3'h0;
                  end
                  else
                  begin
                     // Keep or drop the trial bit, then try the next lower one.
                     sar <= (comp_out ? sar : sar & ~(8'h01 << bit_idx))
                            | (8'h01 << (bit_idx - 3'h1)); // R6 R5
                     bit_idx <= bit_idx - 3'h1;
                  end
               end
         endcase
      end
   end

   a_seq_start: assert property (@(posedge aclk) disable iff (!aresetn) // R9
      ctrl_wr |=> state == SADC_WAIT ##1 state == SADC_SAMPLE) else $error("late sequence start");
   a_sar_step: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      state == SADC_CONV && tick && !last_bit && !ctrl_wr
      |=> sar[bit_idx + 3'h1] == $past(comp_out) && sar[bit_idx]) else $error("bad trial step");
   a_single_halt: assert property (@(posedge aclk) disable iff (!aresetn) // R15
      seq_end && !scan && !ctrl_wr |=> state == SADC_IDLE) else $error("single sequence ran on");

   // A result blocked by a read this cycle is dropped into place next cycle.
   logic       res_pend;
   logic [1:0] pend_idx;
   logic [7:0] pend_val;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         res_pend <= 1'b0;
         pend_idx <= 2'h0;
         pend_val <= 8'h00;
      end
      else
      begin
         res_pend <= conv_end && rd_go;
         pend_idx <= conv_idx;
         pend_val <= sar_final;
      end
   end

   for (genvar i = 0; i < 4; i++)
   begin : g_res
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            result[i] <= 8'h00;
         else if (res_wr && conv_idx == 2'(i))
            result[i] <= sar_final; // R7 R1 R4
         else if (res_pend && pend_idx == 2'(i))
            result[i] <= pend_val; // R12
      end
   end

   a_res_stable: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      rd_go |=> $stable({result[3], result[2], result[1], result[0]})) else $error("result read clash");

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         conv_complete_flag <= 1'b0;
      else if (ctrl_wr)
         conv_complete_flag <= 1'b0; // R17
      else if (seq_end)
         conv_complete_flag <= 1'b1; // R11 R17
   end

   a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      seq_end && !ctrl_wr |=> conv_complete_flag) else $error("complete flag not set");
   a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R17
      ctrl_wr |=> !conv_complete_flag) else $error("complete flag not cleared");

   // Sticky event: set wins over write-one-to-clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         istat <= 1'b0;
      else if (seq_end && !first_done)
         istat <= 1'b1;
      else if (ist_wr && w_data[0])
         istat <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq           <= 1'b0;
         mux_select    <= 4'h0;
         sample_switch <= 1'b0;
      end
      else
      begin
         irq           <= istat && imask;
         mux_select    <= next_mux; // R3 R16
         sample_switch <= state == SADC_SAMPLE; // R8
      end
   end
endmodule

//--- sadc_afe_model.sv
// Purpose: Analog front end model: input selector, sample capacitor and comparator.
// Assumes: Comparator is high while the held sample is at or above the trial code.
// Notes: Reference codes are full scale, zero and a mid value chosen here.
`timescale 1ns/1ps
module sadc_afe_model
   import sadc_pkg::*;
#(
   parameter logic [7:0] MID_CODE = 8'h80
)
(
   input  wire logic       aclk,
   input  wire logic [7:0] ain [8],
   input  wire logic [3:0] mux_select,
   input  wire logic       sample_switch,
   input  wire logic [7:0] dac_trial,
   output      logic       comp_out
);
   logic [7:0] level;
   logic [7:0] held = 8'h00;
   assign level = !mux_select[3] ? ain[mux_select[2:0]] : (mux_select == SEL_REF_HIGH) ? 8'hFF
                  : (mux_select == SEL_REF_LOW) ? 8'h00 : MID_CODE;
   // The capacitor keeps the last level seen while the switch was closed.
   always_ff @(posedge aclk)
   begin
      if (sample_switch)
         held <= level;
   end
   assign comp_out = (held >= dac_trial);
endmodule

//--- tb_sar_adc_sequencer.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Each converted code equals the level held by the front end model.
// Notes: Input levels are random from a fixed seed.
`timescale 1ns/1ps
module tb_sar_adc_sequencer;
   import sadc_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic [3:0]  mux_select;
   logic        sample_switch;
   logic [7:0]  dac_trial;
   logic        comp_out;
   logic        irq;
   logic [7:0]  ain [8];
   logic [31:0] rv;
   logic [1:0]  rr;
   logic [7:0]  keep;
   int          mismatches = 0;
   int          compares = 0;

   sadc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mux_select,
      .sample_switch, .dac_trial, .comp_out, .irq);
   sadc_afe_model afe (.aclk, .ain, .mux_select, .sample_switch, .dac_trial, .comp_out);

   initial forever #2.5 aclk = ~aclk;

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic timeout(input string what);
      chk(what, 32'h1, 32'h0);
      end_sim();
   endtask

   // Write and read release each channel at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      if (n == 50)
         timeout("bvalid");
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      if (n == 50)
         timeout("rvalid");
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   function automatic logic [7:0] expv(input logic [3:0] s);
      case (s)
         SEL_REF_HIGH: return 8'hFF;
         SEL_REF_LOW:  return 8'h00;
         SEL_REF_MID:  return 8'h80;
         default:      return ain[s[2:0]];
      endcase
   endfunction

   task automatic wait_done();
      int k;
      for (k = 0; k < 4000; k++)
      begin
         rd(CTRL_OFF);
         if (rv[CCF_BIT] === 1'b1)
            break;
      end
      if (k == 4000)
         timeout("conv_complete_flag");
   endtask

   task automatic check_results(input logic [5:0] c);
      for (int i = 0; i < 4; i++)
      begin
         rd(RES0_OFF + 8'(4 * i));
         chk("result", {24'h0, c[MULTI_CHANNEL_BIT] ? expv({c[3:2], 2'(i)}) : expv(c[3:0])}, rv);
      end
   endtask

   task automatic conv(input logic [7:0] c);
      wr(CTRL_OFF, {24'h0, c});
      wait_done();
      chk("conv_ctrl_status", {24'h0, 2'b10, c[5:0]}, rv);
      check_results(c[5:0]);
   endtask

   task automatic new_levels();
      @(posedge aclk);
      foreach (ain[i])
         ain[i] <= 8'($urandom);
   endtask

   initial
   begin
      void'($urandom(32'h5f6cf647));
      foreach (ain[i])
         ain[i] = 8'($urandom);
      ain[0] = 8'h00;
      ain[7] = 8'hFF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL_OFF);
      chk("ctrl_reset", 32'h0, rv);
      chk("switch_idle", 32'h0, {31'h0, sample_switch});
      $display("test reset done");
      for (int s = 0; s < 15; s++)
         if (s < 8 || s > 11)
            conv(8'(s));
      $display("test single channel done");
      new_levels();
      conv({4'h1, 2'b00, 2'($urandom)});
      conv({4'h1, 2'b01, 2'($urandom)});
      $display("test multi channel done");
      wr(OPT_OFF, 32'h1);
      wr(CTRL_OFF, 32'h03);
      repeat (300) @(posedge aclk);
      rd(CTRL_OFF);
      chk("rc_slow_flag", 32'h03, rv);
      wait_done();
      check_results(6'h03);
      wr(OPT_OFF, 32'h0);
      $display("test rc clock done");
      wr(CTRL_OFF, 32'h4E);
      repeat (20) @(posedge aclk);
      rd(CTRL_OFF);
      chk("ctrl_flag_clear", 32'h0E, rv);
      new_levels();
      conv(8'h02);
      $display("test abort done");
      conv(8'h23);
      keep = ain[3];
      @(posedge aclk);
      ain[3] <= ~keep;
      repeat (200) @(posedge aclk);
      check_results(6'h23);
      rd(CTRL_OFF);
      chk("scan_flag", 32'hA3, rv);
      conv(8'h03);
      keep = ain[3];
      @(posedge aclk);
      ain[3] <= ~keep;
      repeat (200) @(posedge aclk);
      chk("single_halt", 32'h0, {31'h0, sample_switch});
      for (int i = 0; i < 4; i++)
      begin
         rd(RES0_OFF + 8'(4 * i));
         chk("single_keep", {24'h0, keep}, rv);
      end
      $display("test scan done");
      wr(ISTAT_OFF, 32'h1);
      wr(IMASK_OFF, 32'h1);
      chk("irq_clear", 32'h0, {31'h0, irq});
      conv(8'h01);
      repeat (2) @(posedge aclk);
      chk("irq_set", 32'h1, {31'h0, irq});
      wr(ISTAT_OFF, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq_w1c", 32'h0, {31'h0, irq});
      wr(IMASK_OFF, 32'h0);
      conv(8'h02);
      repeat (2) @(posedge aclk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      rd(ISTAT_OFF);
      chk("int_status", 32'h1, rv);
      rd(8'h40);
      chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
      chk("unmapped_rdata", 32'h0, rv);
      wr(8'h40, 32'h0);
      chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
      $display("test interrupt and bus done");
      conv(8'h25);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (50) @(posedge aclk);
      chk("idle_rst2", 32'h0, {31'h0, sample_switch});
      chk("irq_rst2", 32'h0, {31'h0, irq});
      rd(CTRL_OFF);
      chk("ctrl_rst2", 32'h0, rv);
      rd(RES1_OFF);
      chk("res_rst2", 32'h0, rv);
      $display("test second reset done");
      end_sim();
   end
endmodule
